// >>> logic/spcr_cfg.svh
/*
  Offsets, field positions, reset values and counts for the serial
  port configuration register bank. Definitions only.
*/
`ifndef SPCR_CFG_SVH
`define SPCR_CFG_SVH

`define SPCR_ADDR_W      13
`define SPCR_OFS_CFG     13'h000
`define SPCR_OFS_PARTID  13'h003
`define SPCR_OFS_RDSEL   13'h004
`define SPCR_OFS_VERLO   13'h005
`define SPCR_OFS_VERHI   13'h006
`define SPCR_OFS_UPDATE  13'h232
`define SPCR_OFS_STUPD   13'ha15
`define SPCR_OFS_STEND   13'ha16
`define SPCR_OFS_NVSTAT  13'hb00
`define SPCR_OFS_NVERR   13'hb01
`define SPCR_OFS_NVCTL1  13'hb02
`define SPCR_OFS_NVCTL2  13'hb03

`define SPCR_CFG_UNIDIR  7
`define SPCR_CFG_LSB     6
`define SPCR_CFG_SRST    5
`define SPCR_RDSEL_ACT   0
`define SPCR_UPD_BIT     0
`define SPCR_CTL1_WREN   0
`define SPCR_CTL1_LOAD   1
`define SPCR_CTL2_STORE  0

`define SPCR_ZERO8       8'h00
`define SPCR_ZERO16      16'h0000
`define SPCR_STUPD_RST   8'h80
`define SPCR_STEND_RST   8'hff
`define SPCR_PARTID_DEF  8'h5a

`define SPCR_INSN_BITS   4'hf
`define SPCR_INSN_RW     15
`define SPCR_INSN_WHI    14
`define SPCR_INSN_WLO    13
`define SPCR_W_STREAM    2'h3
`define SPCR_BYTE_LAST   3'h7

`define SPCR_NVM_BYTES   2'h3
`define SPCR_NVM_AW      2
`define SPCR_SYNC_INIT   5'h08

`endif

// >>> logic/spcr_pkg.sv
/*
  Types for the serial port configuration register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spcr_pkg;

  typedef struct packed {
    logic sclk;
    logic csN;
    logic sdio;
  } spcr_pin_in_t;

  typedef struct packed {
    logic sdioOut;
    logic sdioOe;
    logic sdoOut;
    logic sdoOe;
  } spcr_pin_out_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [1:0] addr;
    logic [7:0] wdata;
  } spcr_nvm_req_t;

  typedef enum logic [1:0] {SP_INSN, SP_DATA, SP_DONE} spcr_phase_t;
  typedef enum logic [1:0] {NV_IDLE, NV_ACCESS, NV_CHECK} spcr_nv_state_t;

endpackage

// >>> logic/spcr_sync.sv
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes each bit is an independent slowly changing level.
*/
`timescale 1ns/1ps
module spcr_sync #(
  parameter int                WIDTH = 1,
  parameter logic [WIDTH-1:0]  INIT  = '0
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// >>> logic/spcr_nvm_seq.sv
/*
  Nonvolatile store sequencer: loads or stores the version bytes and a
  check byte. Assumes a same-clock memory port that acks each access.
*/
`timescale 1ns/1ps
`include "spcr_cfg.svh"
module spcr_nvm_seq (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   startLoad,
  input  wire logic                   startStore,
  input  wire logic [15:0]            storeData,
  output logic      [15:0]            loadData,
  output logic                        loadValid,
  output logic                        busy,
  output logic                        dataErr,
  output logic                        done,
  output spcr_pkg::spcr_nvm_req_t     nvmReq,
  input  wire logic [7:0]             nvmRdata,
  input  wire logic                   nvmAck
);
  import spcr_pkg::*;

  spcr_nv_state_t       state_r;
  logic                 store_r;
  logic [1:0]           idx_r;
  logic [23:0]          buf_r;
  logic [7:0]           check;

  assign check = ~(buf_r[7:0] ^ buf_r[15:8]);
  assign busy  = (state_r != NV_IDLE);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= NV_IDLE;
      store_r   <= 1'b0;
      idx_r     <= 2'h0;
      buf_r     <= 24'h000000;
      nvmReq    <= '0;
      loadData  <= `SPCR_ZERO16;
      loadValid <= 1'b0;
      dataErr   <= 1'b0;
      done      <= 1'b0;
    end else begin
      loadValid <= 1'b0;
      done      <= 1'b0;
      case (state_r)
        NV_IDLE: begin
          idx_r <= 2'h0;
          if (startStore) begin
            store_r      <= 1'b1;
            buf_r        <= {~(storeData[7:0] ^ storeData[15:8]),
                             storeData};
            nvmReq.req   <= 1'b1;
            nvmReq.we    <= 1'b1;
            nvmReq.addr  <= 2'h0;
            nvmReq.wdata <= storeData[7:0];
            state_r      <= NV_ACCESS;
          end else if (startLoad) begin
            store_r     <= 1'b0;
            dataErr     <= 1'b0;
            nvmReq.req  <= 1'b1;
            nvmReq.we   <= 1'b0;
            nvmReq.addr <= 2'h0;
            state_r     <= NV_ACCESS;
          end
        end
        NV_ACCESS: begin
          if (nvmAck) begin
            if (!store_r) begin
              buf_r <= {nvmRdata, buf_r[23:8]};
            end
            if (idx_r == `SPCR_NVM_BYTES - 2'h1) begin
              nvmReq.req <= 1'b0;
              state_r    <= NV_CHECK;
            end else begin
              idx_r        <= idx_r + 2'h1;
              nvmReq.addr  <= idx_r + 2'h1;
              // Byte 1 is the high version byte, byte 2 the check byte
              nvmReq.wdata <= (idx_r == 2'h0) ? buf_r[15:8] : buf_r[23:16];
            end
          end
        end
        NV_CHECK: begin
          // Bad check byte keeps the registers untouched
          if (!store_r) begin
            if (buf_r[23:16] == check) begin
              loadData  <= buf_r[15:0];
              loadValid <= 1'b1;
            end else begin
              dataErr <= 1'b1;
            end
          end
          done    <= 1'b1;
          state_r <= NV_IDLE;
        end
        default: state_r <= NV_IDLE;
      endcase
    end
  end
endmodule

// >>> logic/spcr_serial_regs.sv
/*
  Serial control port slave and configuration/nonvolatile control
  register bank. Assumes pins from outside the clock domain, a same-clock
  nonvolatile memory port, and an external tri-state resolver.
*/
// Functional notes
// - Bit 7 clear: reads on data pin, output pin idle; set: reads on output.
// - Bit 6 clear: MSB first, address decrements; set: LSB first, increments.
// - Bit order and address direction are ignored in two-wire mode.
// - Writing bit 5 soft-resets; reload from store if select pin high.
// - Read-only identification byte at 0x003; writes ignored.
// - Bit 0 at readback_source_select picks buffered (0) or active (1) readback.
`timescale 1ns/1ps
`include "spcr_cfg.svh"
module spcr_serial_regs #(
  parameter logic [7:0] VARIANT_IDENTIFICATION = `SPCR_PARTID_DEF // Arbitrary value
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire spcr_pkg::spcr_pin_in_t  pinIn,
  output spcr_pkg::spcr_pin_out_t      pinOut,
  input  wire logic                    eepromSelPin,
  input  wire logic                    i2cModePin,
  output spcr_pkg::spcr_nvm_req_t      nvmReq,
  input  wire logic [7:0]              nvmRdata,
  input  wire logic                    nvmAck,
  output logic [15:0]                  verIdActive
);
  import spcr_pkg::*;

  localparam int AW = `SPCR_ADDR_W;

  logic [4:0]     pinsRaw;
  logic [4:0]     pinsSync;
  logic           sclkS;
  logic           csNS;
  logic           sdioS;
  logic           eeSelS;
  logic           i2cS;
  logic           sclkPrev_r;
  logic           rise;
  logic           fall;

  logic           unidir_r;
  logic           lsb_r;
  logic           lsbEff;
  logic           softRst_r;
  logic           readSel_r;
  logic [15:0]    verBuf_r;
  logic [15:0]    verAct_r;
  logic [7:0]     stUpd_r;
  logic [7:0]     stEnd_r;
  logic           wrEnable_r;
  logic           loadCmd_r;
  logic           storeCmd_r;

  spcr_phase_t    phase_r;
  logic [3:0]     bitCnt_r;
  logic [15:0]    insn_r;
  logic [15:0]    insnNxt;
  logic [AW-1:0]  addr_r;
  logic [AW-1:0]  addrStep;
  logic [7:0]     rx_r;
  logic [7:0]     rxNxt;
  logic [7:0]     tx_r;
  logic [1:0]     byteCnt_r;
  logic           outBit_r;
  logic           isRead;
  logic           byteEnd;
  logic           lastByte;
  logic           wrEn;

  logic           startLoad;
  logic           startStore;
  logic [15:0]    loadData;
  logic           loadValid;
  logic           nvBusy;
  logic           nvErr;
  logic           nvDone;

  assign pinsRaw = {pinIn.sclk, pinIn.csN, pinIn.sdio, eepromSelPin,
                    i2cModePin};

  spcr_sync #(
    .WIDTH (5),
    .INIT  (`SPCR_SYNC_INIT)
  ) uSync (
    .clock (clock),
    .rst   (rst),
    .d     (pinsRaw),
    .q     (pinsSync)
  );

  assign sclkS  = pinsSync[4];
  assign csNS   = pinsSync[3];
  assign sdioS  = pinsSync[2];
  assign eeSelS = pinsSync[1];
  assign i2cS   = pinsSync[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclkPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= sclkS;
    end
  end

  assign rise = sclkS & ~sclkPrev_r & ~csNS;
  assign fall = ~sclkS & sclkPrev_r & ~csNS;

  assign lsbEff   = lsb_r & ~i2cS;
  assign insnNxt  = lsbEff ? {sdioS, insn_r[15:1]}
                           : {insn_r[14:0], sdioS};
  assign rxNxt    = lsbEff ? {sdioS, rx_r[7:1]} : {rx_r[6:0], sdioS};
  assign addrStep = lsbEff ? addr_r + 1'b1 : addr_r - 1'b1;
  assign isRead   = insn_r[`SPCR_INSN_RW];
  assign byteEnd  = rise & (phase_r == SP_DATA) &
                    (bitCnt_r[2:0] == `SPCR_BYTE_LAST);
  assign lastByte = (insn_r[`SPCR_INSN_WHI:`SPCR_INSN_WLO] != `SPCR_W_STREAM)
                  & (byteCnt_r == insn_r[`SPCR_INSN_WHI:`SPCR_INSN_WLO]);
  assign wrEn     = byteEnd & ~isRead;

  function automatic logic [7:0] readByte(input logic [AW-1:0] a);
    logic [7:0] v;
    v = `SPCR_ZERO8;
    case (a)
      `SPCR_OFS_CFG:    v = {unidir_r, lsb_r, 4'h0, lsb_r, unidir_r};
      `SPCR_OFS_PARTID: v = VARIANT_IDENTIFICATION;
      `SPCR_OFS_RDSEL:  v = {7'h00, readSel_r};
      `SPCR_OFS_VERLO:  v = readSel_r ? verAct_r[7:0] : verBuf_r[7:0];
      `SPCR_OFS_VERHI:  v = readSel_r ? verAct_r[15:8]
                                      : verBuf_r[15:8];
      `SPCR_OFS_STUPD:  v = stUpd_r;
      `SPCR_OFS_STEND:  v = stEnd_r;
      `SPCR_OFS_NVSTAT: v = {7'h00, nvBusy};
      `SPCR_OFS_NVERR:  v = {7'h00, nvErr};
      `SPCR_OFS_NVCTL1: v = {6'h00, loadCmd_r, wrEnable_r};
      `SPCR_OFS_NVCTL2: v = {7'h00, storeCmd_r};
      default:          v = `SPCR_ZERO8;
    endcase
    return v;
  endfunction

  // Serial frame sequencing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_r   <= SP_INSN;
      bitCnt_r  <= 4'h0;
      insn_r    <= `SPCR_ZERO16;
      addr_r    <= '0;
      rx_r      <= `SPCR_ZERO8;
      tx_r      <= `SPCR_ZERO8;
      byteCnt_r <= 2'h0;
    end else if (csNS) begin
      phase_r   <= SP_INSN;
      bitCnt_r  <= 4'h0;
      byteCnt_r <= 2'h0;
    end else if (rise) begin
      case (phase_r)
        SP_INSN: begin
          insn_r   <= insnNxt;
          bitCnt_r <= bitCnt_r + 4'h1;
          if (bitCnt_r == `SPCR_INSN_BITS) begin
            phase_r  <= SP_DATA;
            bitCnt_r <= 4'h0;
            addr_r   <= insnNxt[AW-1:0];
            tx_r     <= readByte(insnNxt[AW-1:0]);
          end
        end
        SP_DATA: begin
          rx_r     <= rxNxt;
          bitCnt_r <= bitCnt_r + 4'h1;
          if (byteEnd) begin
            bitCnt_r  <= 4'h0;
            addr_r    <= addrStep;
            tx_r      <= readByte(addrStep);
            byteCnt_r <= byteCnt_r + 2'h1;
            if (lastByte) begin
              phase_r <= SP_DONE;
            end
          end
        end
        SP_DONE: bitCnt_r <= 4'h0;
        default: phase_r <= SP_INSN;
      endcase
    end
  end

  // Read data changes on the falling serial clock edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outBit_r <= 1'b0;
    end else if (fall) begin
      outBit_r <= lsbEff ? tx_r[bitCnt_r[2:0]]
                         : tx_r[3'h7 - bitCnt_r[2:0]];
    end
  end

  always_comb begin
    pinOut.sdioOut = outBit_r;
    pinOut.sdoOut  = outBit_r;
    pinOut.sdioOe  = ~unidir_r & ~csNS & isRead &
                     (phase_r == SP_DATA);
    pinOut.sdoOe   = unidir_r & ~csNS;
  end

  // Port configuration; upper nibble governs, lower is the mirror
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unidir_r  <= 1'b0;
      lsb_r     <= 1'b0;
      softRst_r <= 1'b0;
    end else begin
      softRst_r <= wrEn & (addr_r == `SPCR_OFS_CFG) &
                   rxNxt[`SPCR_CFG_SRST];
      if (softRst_r) begin
        unidir_r <= 1'b0;
        lsb_r    <= 1'b0;
      end else if (wrEn && addr_r == `SPCR_OFS_CFG) begin
        unidir_r <= rxNxt[`SPCR_CFG_UNIDIR];
        lsb_r    <= rxNxt[`SPCR_CFG_LSB];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readSel_r <= 1'b0;
    end else if (softRst_r) begin
      readSel_r <= 1'b0;
    end else if (wrEn && addr_r == `SPCR_OFS_RDSEL) begin
      readSel_r <= rxNxt[`SPCR_RDSEL_ACT];
    end
  end

  // Buffered version bytes, applied by the update strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      verBuf_r <= `SPCR_ZERO16;
      verAct_r <= `SPCR_ZERO16;
    end else if (softRst_r) begin
      verBuf_r <= `SPCR_ZERO16;
      verAct_r <= `SPCR_ZERO16;
    end else if (loadValid) begin
      verBuf_r <= loadData;
      verAct_r <= loadData;
    end else if (wrEn) begin
      if (addr_r == `SPCR_OFS_VERLO) begin
        verBuf_r[7:0] <= rxNxt;
      end
      if (addr_r == `SPCR_OFS_VERHI) begin
        verBuf_r[15:8] <= rxNxt;
      end
      if (addr_r == `SPCR_OFS_UPDATE && rxNxt[`SPCR_UPD_BIT]) begin
        verAct_r <= verBuf_r;
      end
    end
  end

  assign verIdActive = verAct_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stUpd_r <= `SPCR_STUPD_RST;
      stEnd_r <= `SPCR_STEND_RST;
    end else if (softRst_r) begin
      stUpd_r <= `SPCR_STUPD_RST;
      stEnd_r <= `SPCR_STEND_RST;
    end else if (wrEn) begin
      if (addr_r == `SPCR_OFS_STUPD) begin
        stUpd_r <= rxNxt;
      end
      if (addr_r == `SPCR_OFS_STEND) begin
        stEnd_r <= rxNxt;
      end
    end
  end

  // Load and store commands; busy blocks a second request
  assign startLoad  = ~nvBusy & ~loadCmd_r & ~storeCmd_r &
                      ((softRst_r & eeSelS) |
                       (wrEn & (addr_r == `SPCR_OFS_NVCTL1) &
                        rxNxt[`SPCR_CTL1_LOAD]));
  assign startStore = ~nvBusy & ~loadCmd_r & ~storeCmd_r & wrEnable_r &
                      wrEn & (addr_r == `SPCR_OFS_NVCTL2) &
                      rxNxt[`SPCR_CTL2_STORE];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrEnable_r <= 1'b0;
      loadCmd_r  <= 1'b0;
      storeCmd_r <= 1'b0;
    end else begin
      if (softRst_r) begin
        wrEnable_r <= 1'b0;
      end else if (wrEn && addr_r == `SPCR_OFS_NVCTL1) begin
        wrEnable_r <= rxNxt[`SPCR_CTL1_WREN];
      end
      if (startLoad) begin
        loadCmd_r <= 1'b1;
      end else if (nvDone) begin
        loadCmd_r <= 1'b0;
      end
      if (startStore) begin
        storeCmd_r <= 1'b1;
      end else if (nvDone) begin
        storeCmd_r <= 1'b0;
      end
    end
  end

  spcr_nvm_seq uNvm (
    .clock      (clock),
    .rst        (rst),
    .startLoad  (startLoad),
    .startStore (startStore),
    .storeData  (verBuf_r),
    .loadData   (loadData),
    .loadValid  (loadValid),
    .busy       (nvBusy),
    .dataErr    (nvErr),
    .done       (nvDone),
    .nvmReq     (nvmReq),
    .nvmRdata   (nvmRdata),
    .nvmAck     (nvmAck)
  );

endmodule

// >>> verif/spcr_serial_regs_assertions.sv
/*
  Port checker for the serial configuration register bank.
  Assumes one clock domain; bound to the top module below.
*/
`timescale 1ns/1ps
module spcr_serial_regs_assertions (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire spcr_pkg::spcr_pin_in_t  pinIn,
  input  wire spcr_pkg::spcr_pin_out_t pinOut,
  input  wire logic                    eepromSelPin,
  input  wire logic                    i2cModePin,
  input  wire spcr_pkg::spcr_nvm_req_t nvmReq,
  input  wire logic [7:0]              nvmRdata,
  input  wire logic                    nvmAck,
  input  wire logic [15:0]             verIdActive
);
  import spcr_pkg::*;

  logic [7:0] loByte_r;
  logic [7:0] hiByte_r;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Version bytes as the memory hands them over
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loByte_r <= 8'h00;
      hiByte_r <= 8'h00;
    end else if (nvmReq.req && nvmAck && !nvmReq.we) begin
      if (nvmReq.addr == 2'h0) loByte_r <= nvmRdata;
      if (nvmReq.addr == 2'h1) hiByte_r <= nvmRdata;
    end
  end

  sequence lastRead;
    nvmReq.req && nvmAck && !nvmReq.we && nvmReq.addr == 2'h2;
  endsequence
  sequence checkGood;
    lastRead ##0 (nvmRdata == ~(loByte_r ^ hiByte_r));
  endsequence
  sequence checkBad;
    lastRead ##0 (nvmRdata != ~(loByte_r ^ hiByte_r));
  endsequence

  one_driver_a: assert property (!(pinOut.sdioOe && pinOut.sdoOe))
    else $error("both data pins driven");
  sdo_idle_a: assert property (pinIn.csN [*4] |-> !pinOut.sdoOe)
    else $error("output pin driven while deselected");
  sdio_idle_a: assert property (pinIn.csN [*4] |-> !pinOut.sdioOe)
    else $error("data pin driven while deselected");
  req_hold_a: assert property (nvmReq.req && !nvmAck |=> nvmReq.req
    && $stable(nvmReq.addr) && $stable(nvmReq.wdata))
    else $error("memory request changed before ack");
  addr_step_a: assert property (nvmReq.req && nvmAck
    && nvmReq.addr != 2'h2 |=> nvmReq.req
    && nvmReq.addr == $past(nvmReq.addr) + 2'h1)
    else $error("memory address did not step");
  req_drop_a: assert property (nvmReq.req && nvmAck
    && nvmReq.addr == 2'h2 |=> !nvmReq.req)
    else $error("memory request held after last byte");
  req_first_a: assert property ($rose(nvmReq.req)
    |-> nvmReq.addr == 2'h0)
    else $error("memory transfer not started at byte 0");
  load_apply_a: assert property (checkGood
    |-> ##[1:3] verIdActive == {hiByte_r, loByte_r})
    else $error("loaded version not applied");
  bad_keep_a: assert property (checkBad
    |=> $stable(verIdActive) [*3])
    else $error("bad stored data was applied");
endmodule

bind spcr_serial_regs spcr_serial_regs_assertions chk_u (
  .clock(clock), .rst(rst), .pinIn(pinIn), .pinOut(pinOut),
  .eepromSelPin(eepromSelPin), .i2cModePin(i2cModePin), .nvmReq(nvmReq),
  .nvmRdata(nvmRdata), .nvmAck(nvmAck), .verIdActive(verIdActive));

// >>> verif/spcr_host_model.sv
/*
  Host controller on the serial pins and the nonvolatile memory model.
  Assumes the bench calls xfer and sets lsb and uni between frames.
*/
`timescale 1ns/1ps
module spcr_host_model (
  input  wire logic                    clock,
  output spcr_pkg::spcr_pin_in_t       pinIn,
  input  wire spcr_pkg::spcr_pin_out_t pinOut,
  input  wire spcr_pkg::spcr_nvm_req_t nvmReq,
  output logic [7:0]                   nvmRdata,
  output logic                         nvmAck
);
  import spcr_pkg::*;

  logic       sclk_r = 1'b0;
  logic       csN_r = 1'b1;
  logic       dat_r = 1'b0;
  logic       ack_r = 1'b0;
  logic [7:0] rdat_r = 8'h00;
  logic       lsb = 1'b0;
  logic       uni = 1'b0;
  logic       sawSdio = 1'b0;
  logic       sawSdo = 1'b0;
  logic [7:0] mem [3] = '{8'h34, 8'h12, 8'hd9};

  // Shared data wire: device drive wins while its enable is up
  assign pinIn = {sclk_r, csN_r, pinOut.sdioOe ? pinOut.sdioOut : dat_r};
  assign nvmAck = ack_r;
  assign nvmRdata = rdat_r;

  always @(posedge clock) begin
    ack_r <= nvmReq.req && !ack_r;
    rdat_r <= ~rdat_r;
    if (nvmReq.req && !ack_r) begin
      rdat_r <= mem[nvmReq.addr];
      if (nvmReq.we) mem[nvmReq.addr] <= nvmReq.wdata;
    end
    if (pinOut.sdioOe === 1'b1) sawSdio <= 1'b1;
    if (pinOut.sdoOe === 1'b1) sawSdo <= 1'b1;
  end

  // One frame: instruction, nb data bytes; 6 clocks per clock half
  task automatic xfer(input logic [15:0] ins, input logic [15:0] wd,
                      output logic [15:0] rd, input int nb);
    int k;
    rd = 16'h0000;
    sawSdio = 1'b0;
    sawSdo = 1'b0;
    @(posedge clock);
    csN_r <= 1'b0;
    for (int i = 0; i < 16 + 8 * nb; i++) begin
      // Bit position of this data bit; byte n sits at wd/rd[8n+7:8n]
      k = (i - 16) / 8 * 8 + (lsb ? (i - 16) % 8 : 7 - (i - 16) % 8);
      sclk_r <= 1'b0;
      if (i < 16) dat_r <= lsb ? ins[i] : ins[15-i];
      else if (ins[15]) dat_r <= ~dat_r;
      else dat_r <= wd[k];
      repeat (6) @(posedge clock);
      // Undriven output pin reads as the inverse of its last value
      if (i >= 16) rd[k] = uni ? (pinOut.sdoOe ? pinOut.sdoOut
                                               : ~pinOut.sdoOut)
                               : pinIn.sdio;
      sclk_r <= 1'b1;
      repeat (6) @(posedge clock);
    end
    sclk_r <= 1'b0;
    repeat (6) @(posedge clock);
    csN_r <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
endmodule

// >>> verif/serial_port_config_regs_bench.sv
/*
  Self-checking bench for the serial configuration register bank.
  Assumes the host model drives the pins and answers the memory port.
*/
`timescale 1ns/1ps
module serial_port_config_regs_bench;
  import spcr_pkg::*;

  localparam logic [7:0] VARIANT_IDENTIFICATION = 8'h3c; // Arbitrary value

  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          eepromSelPin = 1'b0;
  logic          i2cModePin = 1'b0;
  spcr_pin_in_t  pinIn;
  spcr_pin_out_t pinOut;
  spcr_nvm_req_t nvmReq;
  logic [7:0]    nvmRdata;
  logic          nvmAck;
  logic [15:0]   verIdActive;
  int            fails = 0;
  int            cmp_count = 0;

  spcr_serial_regs #(.VARIANT_IDENTIFICATION(VARIANT_IDENTIFICATION)) dut_u (
    .clock(clock), .rst(rst), .pinIn(pinIn), .pinOut(pinOut),
    .eepromSelPin(eepromSelPin), .i2cModePin(i2cModePin),
    .nvmReq(nvmReq), .nvmRdata(nvmRdata), .nvmAck(nvmAck),
    .verIdActive(verIdActive));
  spcr_host_model host_u (
    .clock(clock), .pinIn(pinIn), .pinOut(pinOut), .nvmReq(nvmReq),
    .nvmRdata(nvmRdata), .nvmAck(nvmAck));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [15:0] x;
    host_u.xfer({3'b000, a}, {8'h00, d}, x, 1);
  endtask

  task automatic rdChk(input logic [12:0] a, input logic [7:0] exp);
    logic [15:0] v;
    host_u.xfer({3'b100, a}, 16'h0000, v, 1);
    check(v, {8'h00, exp});
  endtask

  // Two-byte frames: address steps down MSB first, up LSB first
  task automatic testBurst();
    logic [15:0] v;
    host_u.xfer({3'b101, 13'ha16}, 16'h0000, v, 2);
    check(v, 16'h80ff);
    host_u.xfer({3'b001, 13'h006}, 16'h5566, v, 2);
    rdChk(13'h006, 8'h66);
    rdChk(13'h005, 8'h55);
    wr(13'h000, 8'h42);
    host_u.lsb = 1'b1;
    host_u.xfer({3'b001, 13'h005}, 16'h3c96, v, 2);
    host_u.xfer({3'b101, 13'h005}, 16'h0000, v, 2);
    check(v, 16'h3c96);
    wr(13'h000, 8'h00);
    host_u.lsb = 1'b0;
  endtask

  task automatic testIdent();
    rdChk(13'h003, VARIANT_IDENTIFICATION);
    wr(13'h003, ~VARIANT_IDENTIFICATION);
    rdChk(13'h003, VARIANT_IDENTIFICATION);
  endtask

  task automatic testReadback();
    rdChk(13'h004, 8'h00);
    wr(13'h005, 8'ha5);
    rdChk(13'h005, 8'ha5);
    wr(13'h004, 8'h01);
    rdChk(13'h005, 8'h00);
    wr(13'h232, 8'h01);
    check(verIdActive, 16'h00a5);
    rdChk(13'h005, 8'ha5);
    wr(13'h004, 8'h00);
  endtask

  task automatic testOrder();
    wr(13'h000, 8'h42);
    host_u.lsb = 1'b1;
    rdChk(13'h000, 8'h42);
    i2cModePin <= 1'b1;
    host_u.lsb = 1'b0;
    rdChk(13'h000, 8'h42);
    i2cModePin <= 1'b0;
    host_u.lsb = 1'b1;
    wr(13'h000, 8'h00);
    host_u.lsb = 1'b0;
    rdChk(13'h000, 8'h00);
  endtask

  task automatic testUnidir();
    wr(13'h000, 8'h81);
    host_u.uni = 1'b1;
    rdChk(13'h003, VARIANT_IDENTIFICATION);
    check({host_u.sawSdo, host_u.sawSdio}, 16'h0002);
    wr(13'h000, 8'h00);
    host_u.uni = 1'b0;
    rdChk(13'h003, VARIANT_IDENTIFICATION);
    check({host_u.sawSdo, host_u.sawSdio}, 16'h0001);
  endtask

  task automatic testNvm();
    wr(13'hb02, 8'h02);
    rdChk(13'hb02, 8'h00);
    rdChk(13'hb00, 8'h00);
    rdChk(13'hb01, 8'h00);
    check(verIdActive, 16'h1234);
    wr(13'h005, 8'h77);
    wr(13'hb02, 8'h01);
    wr(13'hb03, 8'h01);
    rdChk(13'hb03, 8'h00);
    check({host_u.mem[0], host_u.mem[2]},
          {8'h77, ~(8'h77 ^ 8'h12)});
    host_u.mem[2] = ~host_u.mem[2];
    wr(13'hb02, 8'h03);
    rdChk(13'hb01, 8'h01);
    check(verIdActive, 16'h1234);
    wr(13'h000, 8'h24);
    check(verIdActive, 16'h0000);
    rdChk(13'h005, 8'h00);
    host_u.mem[2] = ~(host_u.mem[0] ^ host_u.mem[1]);
    eepromSelPin <= 1'b1;
    wr(13'h000, 8'h24);
    check(verIdActive, 16'h1277);
    rdChk(13'h000, 8'h00);
  endtask

  task results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    forever #2.5 clock = ~clock;
  end

  // About 13k cycles of frames expected; allow a wide margin
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    results();
  end

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    testIdent();
    testReadback();
    testOrder();
    testUnidir();
    testBurst();
    testNvm();
    results();
  end
endmodule
